//--- core/diag_reporter_defines.svh
`ifndef DIAG_REPORTER_DEFINES_SVH
`define DIAG_REPORTER_DEFINES_SVH

// Channel fault classes
`define CLS_COMM_FAIL      16'h0601
`define CLS_CONFIG         16'h0602
`define CLS_SUPPLY         16'h0610
// Channel fault details
`define DET_SLOT_COMM      16'h0682
`define DET_IO_EXCESS      16'h0692
`define DET_PS_EXCESS      16'h069B
`define DET_NO_CONNECTOR   16'h0696
`define DET_MULTI_MASTER   16'h0697
`define DET_POWER_BUDGET   16'h06B1
`define DET_HEAD_SUPPLY    16'h06B2
// Sync watch: loss window and permitted spacing, in clock cycles
`define SYNC_LOSS_CYC      20000
`define SPACING_MIN_CYC    19000
`define SPACING_MAX_CYC    21000
// Station head reports from slot 1
`define HEAD_SLOT          8'h01
// Legacy record format version
`define LEGACY_FMT_VERSION 16'h0101
// Legacy user structure tags, one per fault source except sync upkeep
`define TAG_POWER_BUDGET   16'h0001
`define TAG_PS_EXCESS      16'h0002
`define TAG_IO_EXCESS      16'h0003
`define TAG_NO_CONNECTOR   16'h0004
`define TAG_MULTI_MASTER   16'h0005
`define TAG_SLOT_COMM      16'h0006
`define TAG_HEAD_SUPPLY    16'h0007
// Firmware level where extended diagnostics start (major 4, minor 0)
`define EXT_DIAG_MIN_FW    8'h40
// Fault indicator half period: 250 ms at 50 ns
`define FLASH_HALF_MS      250
`define FLASH_HALF_CYC     ((`FLASH_HALF_MS * 1000000) / 50)

`endif

//--- core/diag_reporter_pkg.sv
`default_nettype none
package diag_reporter_pkg;

  // Fault sources, one pending bit each
  typedef enum logic [2:0] {
    SRC_SLOT_COMM    = 3'h0,
    SRC_IO_EXCESS    = 3'h1,
    SRC_PS_EXCESS    = 3'h2,
    SRC_NO_CONNECTOR = 3'h3,
    SRC_MULTI_MASTER = 3'h4,
    SRC_POWER_BUDGET = 3'h5,
    SRC_HEAD_SUPPLY  = 3'h6,
    SRC_SYNC_UPKEEP  = 3'h7
  } fault_src_t;

  // Reporter states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } report_state_t;

endpackage : diag_reporter_pkg
`default_nettype wire

//--- core/io_station_diagnostic_reporter.sv
`timescale 1ns/100ps
`default_nettype none
`include "diag_reporter_defines.svh"

// Summary of operation
// R1: Track several pending alarms independently.
// R2: Fault indicator flashes while alarms pending.
// R3: Send interrupt per alarm; keep record data.
// R4: Controller buffers every incoming alarm.
// R5: Controller runs handler or stops.
// R6: Missing sync frame raises maintenance demand.
// R7: Sync spacing outside jitter raises maintenance.
// R8: Maintenance indicator steady while demanded.
// R9: Supply module maintenance passed on unchanged.
// R10: Maintenance travels the interrupt path.
// R11: Channel faults readable as diagnostic entries.
// R12: Extended from V4.0, legacy records before.
// R13: Own extended diagnostics name slot 1.
// R14: Slot comm failure 0x0601/0x0682, slot.
// R15: I/O module excess 0x0602/0x0692, slot.
// R16: Supply excess 0x0602/0x069B, slot.
// R17: No connector 0x0602/0x0696, zero.
// R18: Multiple masters 0x0602/0x0697, zero.
// R19: Power budget 0x0610/0x06B1, slot.
// R20: Head supply fault 0x0610/0x06B2, zero.
// R21: Legacy records carry format version 0x0101.
// R22: Interrupt on come and go, if enabled.
// R23: Indicators clear when conditions clear.
module io_station_diagnostic_reporter
  import diag_reporter_pkg::*;
#(
  parameter int unsigned SYNC_TIMEOUT_CYC = `SYNC_LOSS_CYC,   // Loss window
  parameter int unsigned JITTER_MIN_CYC   = `SPACING_MIN_CYC, // Shortest gap
  parameter int unsigned JITTER_MAX_CYC   = `SPACING_MAX_CYC, // Longest gap
  parameter int unsigned FLASH_HALF_CYC   = `FLASH_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Fault condition levels from the station, pin domain
  input  wire logic [6:0]  fault_in,
  // Slot numbers attached to the slot-carrying faults
  input  wire logic [7:0]  comm_slot,
  input  wire logic [7:0]  io_excess_slot,
  input  wire logic [7:0]  ps_excess_slot,
  input  wire logic [7:0]  budget_slot,
  // Sync frame arrival pulse, pin domain
  input  wire logic        sync_frame,
  // Parameter assignment finished: sync watch armed
  input  wire logic        sync_armed,
  // Maintenance event word from a supply module
  input  wire logic        ps_upkeep_valid,
  input  wire logic [15:0] ps_upkeep_event,
  // Configuration
  input  wire logic        diag_irq_enable,
  input  wire logic [7:0]  fw_version,
  // Interrupt handshake with the controller link
  input  wire logic        irq_ack,
  output logic             irq_valid,
  output logic             irq_incoming,
  output logic             irq_upkeep,
  output logic [15:0]      channel_fault_class,
  output logic [15:0]      channel_fault_detail,
  output logic [7:0]       fault_extra_value,
  output logic [7:0]       irq_slot,
  output logic             irq_legacy,
  output logic [15:0]      user_structure_tag,
  output logic [15:0]      record_format_version,
  // Record read port
  input  wire logic        record_read_call,
  input  wire logic [2:0]  record_index,
  output logic             record_valid,
  output logic             record_present,
  output logic [15:0]      record_class,
  output logic [15:0]      record_detail,
  output logic [7:0]       record_value,
  // Indicators
  output logic             fault_indicator,
  output logic             upkeep_indicator
);

  // Encoded fault description
  typedef struct packed {
    logic [15:0] cls;
    logic [15:0] det;
    logic [7:0]  val;
    logic [15:0] tag;
  } code_t;

  // Fault code lookup for a source
  function automatic code_t encode(input logic [2:0] s,
                                   input logic [7:0] cs,
                                   input logic [7:0] ios,
                                   input logic [7:0] pss,
                                   input logic [7:0] bs);
    code_t c;
    c = '{default: '0};
    unique case (s)
      3'h0: c = '{`CLS_COMM_FAIL, `DET_SLOT_COMM, cs, `TAG_SLOT_COMM}; // R14
      3'h1: c = '{`CLS_CONFIG, `DET_IO_EXCESS, ios, `TAG_IO_EXCESS}; // R15
      3'h2: c = '{`CLS_CONFIG, `DET_PS_EXCESS, pss, `TAG_PS_EXCESS}; // R16
      3'h3: c = '{`CLS_CONFIG, `DET_NO_CONNECTOR, 8'h00,
                  `TAG_NO_CONNECTOR}; // R17
      3'h4: c = '{`CLS_CONFIG, `DET_MULTI_MASTER, 8'h00,
                  `TAG_MULTI_MASTER}; // R18
      3'h5: c = '{`CLS_SUPPLY, `DET_POWER_BUDGET, bs,
                  `TAG_POWER_BUDGET}; // R19
      3'h6: c = '{`CLS_SUPPLY, `DET_HEAD_SUPPLY, 8'h00,
                  `TAG_HEAD_SUPPLY}; // R20
      3'h7: c = '{16'h0000, 16'h0000, 8'h00, 16'h0000};
    endcase
    return c;
  endfunction : encode

  // Two-flop synchronisers for pin inputs
  logic [6:0] fault_s1_q, fault_s2_q;
  logic       sync_s1_q, sync_s2_q, sync_s3_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_s1_q <= 7'h00;
      fault_s2_q <= 7'h00;
      sync_s1_q  <= 1'b0;
      sync_s2_q  <= 1'b0;
      sync_s3_q  <= 1'b0;
    end else begin
      fault_s1_q <= fault_in;
      fault_s2_q <= fault_s1_q;
      sync_s1_q  <= sync_frame;
      sync_s2_q  <= sync_s1_q;
      sync_s3_q  <= sync_s2_q;
    end
  end
  // Rising edge of the synchronised frame marker
  logic sync_edge;
  assign sync_edge = sync_s2_q & ~sync_s3_q;

  // Sync frame watchdog and spacing check
  logic [31:0] gap_q;
  logic        seen_q;      // A frame seen since arming
  logic        upkeep_q;    // Maintenance demanded level
  logic        armed_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q    <= 32'h0000_0000;
      seen_q   <= 1'b0;
      upkeep_q <= 1'b0;
      armed_q  <= 1'b0;
    end else begin
      armed_q <= sync_armed;
      if (!sync_armed) begin
        // Disarmed: no demand, watch restarts after assignment
        gap_q    <= 32'h0000_0000;
        seen_q   <= 1'b0;
        upkeep_q <= 1'b0; // R23
      end else if (sync_edge) begin
        gap_q  <= 32'h0000_0000;
        seen_q <= 1'b1;
        // First frame has no previous one to measure against
        if (seen_q && (gap_q < JITTER_MIN_CYC || gap_q > JITTER_MAX_CYC))
          upkeep_q <= 1'b1; // R7
        else
          upkeep_q <= 1'b0; // R23
      end else begin
        if (gap_q != 32'hFFFF_FFFF)
          gap_q <= gap_q + 32'h0000_0001;
        // Timeout covers both start-up and running phases
        if (gap_q >= SYNC_TIMEOUT_CYC)
          upkeep_q <= 1'b1; // R6
      end
    end
  end

  // Pending alarm vector: bit 7 carries the sync maintenance demand
  logic [7:0] cond;
  logic [7:0] pend_q;     // Conditions already reported
  assign cond = {upkeep_q, fault_s2_q}; // R1

  // Captured codes for record reads, one slot per source except sync upkeep
  code_t rec_q [0:6]; // R3
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 7; i++) rec_q[i] <= '{default: '0};
    end else begin
      for (int i = 0; i < 7; i++)
        if (fault_s2_q[i])
          rec_q[i] <= encode(3'(i), comm_slot, io_excess_slot,
                             ps_excess_slot, budget_slot); // R11
    end
  end

  // Record read answer, one cycle after the call
  always_ff @(posedge clk) begin
    if (rst) begin
      record_valid   <= 1'b0;
      record_present <= 1'b0;
      record_class   <= 16'h0000;
      record_detail  <= 16'h0000;
      record_value   <= 8'h00;
    end else begin
      record_valid <= record_read_call;
      if (record_read_call && record_index != 3'h7) begin
        record_present <= fault_s2_q[record_index];
        record_class   <= rec_q[record_index].cls;
        record_detail  <= rec_q[record_index].det;
        record_value   <= rec_q[record_index].val;
      end else if (record_read_call) begin
        record_present <= 1'b0;
        record_class   <= 16'h0000;
        record_detail  <= 16'h0000;
        record_value   <= 8'h00;
      end
    end
  end

  // Lowest-numbered change between condition and reported state
  logic [7:0] diff;
  logic [2:0] pick;
  logic       any_diff;
  assign diff = cond ^ pend_q;
  always_comb begin
    pick     = 3'h0;
    any_diff = 1'b0;
    for (int i = 7; i >= 0; i--)
      if (diff[i]) begin
        pick     = 3'(i);
        any_diff = 1'b1;
      end
  end

  // Interrupt reporter, one event at a time
  report_state_t state_q;
  code_t         cur;
  logic          ext_mode;
  assign ext_mode = (fw_version >= `EXT_DIAG_MIN_FW); // R12
  assign cur = encode(pick, comm_slot, io_excess_slot, ps_excess_slot,
                      budget_slot);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q               <= ST_IDLE;
      pend_q                <= 8'h00;
      irq_valid             <= 1'b0;
      irq_incoming          <= 1'b0;
      irq_upkeep            <= 1'b0;
      channel_fault_class   <= 16'h0000;
      channel_fault_detail  <= 16'h0000;
      fault_extra_value     <= 8'h00;
      irq_slot              <= 8'h00;
      irq_legacy            <= 1'b0;
      user_structure_tag    <= 16'h0000;
      record_format_version <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // Supply module events are passed on word for word
          if (ps_upkeep_valid && diag_irq_enable) begin
            irq_valid            <= 1'b1; // R10
            irq_upkeep           <= 1'b1;
            irq_incoming         <= 1'b1;
            irq_legacy           <= 1'b0;
            channel_fault_class  <= ps_upkeep_event; // R9
            channel_fault_detail <= 16'h0000;
            fault_extra_value    <= 8'h00;
            irq_slot             <= `HEAD_SLOT;
            state_q              <= ST_SEND;
          end else if (any_diff) begin
            pend_q[pick] <= cond[pick]; // R22
            // Disabled interrupts still track state, silently
            if (diag_irq_enable) begin
              irq_valid    <= 1'b1; // R3
              irq_incoming <= cond[pick]; // R22
              irq_upkeep   <= (pick == SRC_SYNC_UPKEEP); // R10
              irq_slot     <= `HEAD_SLOT; // R13
              channel_fault_class  <= cur.cls;
              channel_fault_detail <= cur.det;
              fault_extra_value    <= cur.val;
              irq_legacy <= ~ext_mode; // R12
              user_structure_tag <= ext_mode ? 16'h0000 : cur.tag;
              record_format_version <= ext_mode ? 16'h0000
                                                : `LEGACY_FMT_VERSION; // R21
              state_q <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          // Held until the link accepts
          if (irq_ack) begin
            irq_valid <= 1'b0;
            state_q   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // One idle cycle so ack cannot double-count
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Indicator drive: flash on faults, steady on maintenance
  logic [31:0] flash_cnt_q;
  logic        flash_ph_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_cnt_q      <= 32'h0000_0000;
      flash_ph_q       <= 1'b0;
      fault_indicator  <= 1'b0;
      upkeep_indicator <= 1'b0;
    end else begin
      if (fault_s2_q != 7'h00) begin
        if (flash_cnt_q >= FLASH_HALF_CYC - 1) begin
          flash_cnt_q <= 32'h0000_0000;
          flash_ph_q  <= ~flash_ph_q;
        end else begin
          flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
        end
        fault_indicator <= ~flash_ph_q; // R2
      end else begin
        flash_cnt_q     <= 32'h0000_0000;
        flash_ph_q      <= 1'b0;
        fault_indicator <= 1'b0; // R23
      end
      upkeep_indicator <= upkeep_q | pend_q[7]; // R8
    end
  end

endmodule : io_station_diagnostic_reporter
`default_nettype wire

//--- testbench/ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// Controller side: accepts each interrupt after a chosen wait
module ctrl_model #(
  parameter bit HAS_HANDLER = 1'b1  // Handler routine installed
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        irq_valid,
  input  wire logic        irq_incoming,
  input  wire logic [15:0] channel_fault_class,
  input  wire logic [1:0]  slow,
  output logic             irq_ack,
  output logic [7:0]       n_buf,
  output logic [7:0]       n_hnd,
  output logic [15:0]      start_info,
  output logic             stopped
);
  logic [1:0] wait_q;  // Cycles already stalled
  // Ack lasts one edge, so the word is never accepted twice
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ack    <= 1'b0;
      wait_q     <= 2'h0;
      n_buf      <= 8'h00;
      n_hnd      <= 8'h00;
      start_info <= 16'h0000;
      stopped    <= 1'b0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
    end else if (irq_valid && wait_q == slow) begin
      irq_ack    <= 1'b1;
      wait_q     <= 2'h0;
      n_buf      <= n_buf + {7'h00, irq_incoming};
      start_info <= channel_fault_class;
      if (HAS_HANDLER) begin
        n_hnd <= n_hnd + 8'h01;
      end else begin
        stopped <= 1'b1;
      end
    end else if (irq_valid) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : ctrl_model
`default_nettype wire

//--- testbench/diag_reporter_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Interrupt word, record answer and gating checks at the ports
module diag_reporter_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        diag_irq_enable,
  input wire logic [7:0]  fw_version,
  input wire logic        irq_ack,
  input wire logic        irq_valid,
  input wire logic        irq_upkeep,
  input wire logic        irq_legacy,
  input wire logic [15:0] channel_fault_class,
  input wire logic [15:0] channel_fault_detail,
  input wire logic [7:0]  fault_extra_value,
  input wire logic [7:0]  irq_slot,
  input wire logic [15:0] record_format_version,
  input wire logic        record_read_call,
  input wire logic        record_valid,
  input wire logic        record_present
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Extended fault word standing, not maintenance (supply or sync) nor legacy
  wire        ext_irq = irq_valid && !irq_legacy && !irq_upkeep;
  wire [15:0] cls     = channel_fault_class;
  wire [15:0] det     = channel_fault_detail;
  property p_irq_hold;
    irq_valid && !irq_ack |=> irq_valid && $stable(cls) && $stable(det)
      && $stable(fault_extra_value);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("word moved");
  property p_slot_one;
    ext_irq |-> irq_slot == 8'h01;
  endproperty
  a_slot_one: assert property (p_slot_one) else $error("slot");
  property p_mode_sel;
    irq_valid && !irq_upkeep |-> irq_legacy == (fw_version < 8'h40);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode");
  property p_fmt_ver;
    irq_valid && irq_legacy |-> record_format_version == 16'h0101;
  endproperty
  a_fmt_ver: assert property (p_fmt_ver) else $error("format");
  // Detail picks the class: word 0x0682 comm, nibble 9 config, nibble B supply
  property p_class_map;
    ext_irq |-> (cls == 16'h0601) == (det == 16'h0682)
      && (cls == 16'h0602) == (det[7:4] == 4'h9)
      && (cls == 16'h0610) == (det[7:4] == 4'hB);
  endproperty
  a_class_map: assert property (p_class_map)
    else $error("class");
  property p_zero_val;
    ext_irq && (det inside {16'h0696, 16'h0697, 16'h06B2})
      |-> fault_extra_value == 8'h00;
  endproperty
  a_zero_val: assert property (p_zero_val) else $error("value");
  property p_rec_ans;
    record_valid == $past(record_read_call);
  endproperty
  a_rec_ans: assert property (p_rec_ans) else $error("record");
  property p_irq_gate;
    $rose(irq_valid) |-> $past(diag_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("gate");
  c_legacy: cover property (irq_valid && irq_legacy);
  c_upkeep: cover property (irq_valid && irq_upkeep && irq_ack);
  c_record: cover property (record_valid && record_present);
endmodule : diag_reporter_sva
bind io_station_diagnostic_reporter diag_reporter_sva diag_reporter_sva_i (
  .clk(clk), .rst(rst), .diag_irq_enable(diag_irq_enable),
  .fw_version(fw_version), .irq_ack(irq_ack), .irq_valid(irq_valid),
  .irq_upkeep(irq_upkeep), .irq_legacy(irq_legacy),
  .channel_fault_class(channel_fault_class),
  .channel_fault_detail(channel_fault_detail),
  .fault_extra_value(fault_extra_value), .irq_slot(irq_slot),
  .record_format_version(record_format_version),
  .record_read_call(record_read_call), .record_valid(record_valid),
  .record_present(record_present));
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0, rst = 1'b1, sync_frame = 1'b0;
  logic        sync_armed = 1'b0, ps_upkeep_valid = 1'b0;
  logic        diag_irq_enable = 1'b1, record_read_call = 1'b0;
  logic [6:0]  fault_in = 7'h00;
  logic [7:0]  comm_slot = 8'h05, io_excess_slot = 8'h21;
  logic [7:0]  ps_excess_slot = 8'h03, budget_slot = 8'h07;
  logic [7:0]  fw_version = 8'h40;
  logic [15:0] ps_upkeep_event = 16'h0000;
  logic [2:0]  record_index = 3'h0;
  logic [1:0]  slow = 2'h0;  // Partner stall per interrupt
  logic        irq_ack, irq_valid, irq_incoming, irq_upkeep, irq_legacy;
  logic        record_valid, record_present, stopped, stopped_nh;
  logic        fault_indicator, upkeep_indicator;
  logic [15:0] channel_fault_class, channel_fault_detail, start_info;
  logic [15:0] user_structure_tag, record_format_version;
  logic [15:0] record_class, record_detail;
  logic [7:0]  fault_extra_value, irq_slot, record_value, n_buf, n_hnd;
  int          n_errors = 0;
  int          checked = 0;
  // Expected words per fault source, slots as driven above
  logic [15:0] cls_t[7] = '{16'h0601, 16'h0602, 16'h0602, 16'h0602,
                            16'h0602, 16'h0610, 16'h0610};
  logic [15:0] det_t[7] = '{16'h0682, 16'h0692, 16'h069B, 16'h0696,
                            16'h0697, 16'h06B1, 16'h06B2};
  logic [7:0]  val_t[7] = '{8'h05, 8'h21, 8'h03, 8'h00, 8'h00, 8'h07, 8'h00};
  // Short counts keep the run brief
  io_station_diagnostic_reporter #(
    .SYNC_TIMEOUT_CYC(50), .JITTER_MIN_CYC(40), .JITTER_MAX_CYC(60),
    .FLASH_HALF_CYC(4)
  ) io_station_diagnostic_reporter_i (
    .clk(clk), .rst(rst), .fault_in(fault_in), .comm_slot(comm_slot),
    .io_excess_slot(io_excess_slot), .ps_excess_slot(ps_excess_slot),
    .budget_slot(budget_slot), .sync_frame(sync_frame),
    .sync_armed(sync_armed), .ps_upkeep_valid(ps_upkeep_valid),
    .ps_upkeep_event(ps_upkeep_event), .diag_irq_enable(diag_irq_enable),
    .fw_version(fw_version), .irq_ack(irq_ack), .irq_valid(irq_valid),
    .irq_incoming(irq_incoming), .irq_upkeep(irq_upkeep),
    .channel_fault_class(channel_fault_class),
    .channel_fault_detail(channel_fault_detail),
    .fault_extra_value(fault_extra_value), .irq_slot(irq_slot),
    .irq_legacy(irq_legacy), .user_structure_tag(user_structure_tag),
    .record_format_version(record_format_version),
    .record_read_call(record_read_call), .record_index(record_index),
    .record_valid(record_valid), .record_present(record_present),
    .record_class(record_class), .record_detail(record_detail),
    .record_value(record_value), .fault_indicator(fault_indicator),
    .upkeep_indicator(upkeep_indicator));
  ctrl_model ctrl_model_i (
    .clk(clk), .rst(rst), .irq_valid(irq_valid), .irq_incoming(irq_incoming),
    .channel_fault_class(channel_fault_class), .slow(slow),
    .irq_ack(irq_ack), .n_buf(n_buf), .n_hnd(n_hnd),
    .start_info(start_info), .stopped(stopped));
  // Same partner without a handler routine; watches only, its ack unused
  ctrl_model #(.HAS_HANDLER(1'b0)) ctrl_model_nh_i (
    .clk(clk), .rst(rst), .irq_valid(irq_valid), .irq_incoming(irq_incoming),
    .channel_fault_class(channel_fault_class), .slow(slow),
    .irq_ack(), .n_buf(), .n_hnd(), .start_info(), .stopped(stopped_nh));
  always #25 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic frame;
    sync_frame = 1'b1;
    @(negedge clk);
    sync_frame = 1'b0;
  endtask : frame
  // Kind k: 0 extended, 1 legacy, 2 maintenance; judged while standing
  task automatic get_irq(input logic [15:0] e_c, e_d, e_t,
                         input logic [7:0] e_v, input logic e_i, input int k);
    int i;
    for (i = 0; i < 100 && irq_ack !== 1'b1; i++) @(negedge clk);
    if (irq_ack !== 1'b1) begin
      chk("irq_ack", 16'h1, irq_ack);
      report_and_stop;
    end else begin
      chk("irq_valid", 16'h1, irq_valid);
      chk("irq_upkeep", k == 2, irq_upkeep);
      if (k < 2) chk("irq_legacy", k == 1, irq_legacy);
      if (k < 2) chk("irq_incoming", e_i, irq_incoming);
      if (k == 0) chk("class", e_c, channel_fault_class);
      if (k == 0) chk("detail", e_d, channel_fault_detail);
      if (k == 0) chk("value", e_v, fault_extra_value);
      if (k == 0) chk("irq_slot", 16'h1, irq_slot);
      if (k == 1) chk("tag", e_t, user_structure_tag);
      if (k == 1) chk("format", 16'h0101, record_format_version);
      if (k == 2 && e_c != 16'h0) chk("class", e_c, channel_fault_class);
      @(negedge clk);
    end
  endtask : get_irq
  task automatic rd(input logic [2:0] x, input logic e_p,
                    input logic [15:0] e_c, e_d, input logic [7:0] e_v);
    record_index = x;
    record_read_call = 1'b1;
    @(negedge clk);
    record_read_call = 1'b0;
    chk("record_valid", 16'h1, record_valid);
    chk("record_present", e_p, record_present);
    chk("record_class", e_c, record_class);
    chk("record_detail", e_d, record_detail);
    chk("record_value", e_v, record_value);
    // Gap edge so a following call never re-raises in the same step
    @(negedge clk);
  endtask : rd
  // Sources 0 to 6 come and go; flashing and record read meanwhile
  task automatic t_faults;
    int i, j, hi;
    for (i = 0; i < 7; i++) begin
      fault_in[i] = 1'b1;
      get_irq(cls_t[i], det_t[i], 0, val_t[i],
              1, 0);
      rd(i[2:0], 1'b1, cls_t[i], det_t[i], val_t[i]);
      hi = 0;
      for (j = 0; j < 20; j++) begin
        @(negedge clk);
        hi += int'(fault_indicator === 1'b1);
      end
      chk("fault_indicator", 16'h1, hi >= 8 && hi <= 12);
      fault_in[i] = 1'b0;
      get_irq(cls_t[i], det_t[i], 0, val_t[i], 0, 0);
      cyc(3);
      chk("fault_indicator", 16'h0, fault_indicator);
    end
    rd(3'h7, 1'b0, 16'h0, 16'h0, 8'h0);
  endtask : t_faults
  // Two alarms at once with a slow controller
  task automatic t_multi;
    logic [7:0] nb;
    nb = n_buf;
    slow = 2'h3;
    fault_in[4:3] = 2'b11;
    get_irq(16'h0602, 16'h0696, 0, 8'h00, 1, 0);
    get_irq(16'h0602, 16'h0697, 0, 8'h00, 1, 0);
    rd(3'h3, 1'b1, 16'h0602, 16'h0696, 8'h00);
    rd(3'h4, 1'b1, 16'h0602, 16'h0697, 8'h00);
    chk("n_buf", nb + 8'h2, n_buf);
    fault_in[4:3] = 2'b00;
    get_irq(16'h0602, 16'h0696, 0, 8'h00, 0, 0);
    get_irq(16'h0602, 16'h0697, 0, 8'h00, 0, 0);
    slow = 2'h0;
  endtask : t_multi
  task automatic t_legacy;
    fw_version = 8'h3F;
    fault_in[5] = 1'b1;
    get_irq(0, 0, 16'h0001, 0, 1, 1);
    fault_in[5] = 1'b0;
    get_irq(0, 0, 16'h0001, 0, 0, 1);
    fw_version = 8'h40;
  endtask : t_legacy
  // Supply event passes unchanged and reaches the handler
  task automatic t_supply(input logic en);
    logic [7:0] nh;
    nh = n_hnd;
    diag_irq_enable = en;
    cyc(3);
    ps_upkeep_event = 16'hA5C3;
    ps_upkeep_valid = 1'b1;
    fault_in[0] = !en;
    @(negedge clk);
    ps_upkeep_valid = 1'b0;
    if (en) get_irq(16'hA5C3, 0, 0, 0, 0, 2);
    if (en) chk("start_info", 16'hA5C3, start_info);
    chk("stopped", 16'h0, stopped);
    chk("stopped_nh", 16'h1, stopped_nh);
    cyc(10);
    chk("n_hnd", nh + {7'h0, en}, n_hnd);
    chk("irq_valid", 16'h0, irq_valid);
    fault_in[0] = 1'b0;
    cyc(10);
    diag_irq_enable = 1'b1;
    cyc(10);
    chk("irq_valid", 16'h0, irq_valid);
  endtask : t_supply
  // Frame loss, good spacing, short spacing, then disarm
  task automatic t_sync;
    sync_armed = 1'b1;
    get_irq(0, 0, 0, 0, 0, 2);
    cyc(20);
    chk("upkeep_indicator", 16'h1, upkeep_indicator);
    frame;
    cyc(44);
    frame;
    cyc(10);
    chk("upkeep_indicator", 16'h0, upkeep_indicator);
    cyc(9);
    frame;
    cyc(6);
    chk("upkeep_indicator", 16'h1, upkeep_indicator);
    sync_armed = 1'b0;
    cyc(6);
    chk("upkeep_indicator", 16'h0, upkeep_indicator);
  endtask : t_sync
  initial begin
    cyc(10);
    rst = 1'b0;
    cyc(3);
    t_faults;
    t_multi;
    t_legacy;
    t_supply(1'b1);
    t_supply(1'b0);
    t_sync;
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
